//--- rtl/motor_io_defs.vh
// Constants for the pulse-input motor driver control logic
`ifndef MOTOR_IO_DEFS_VH
`define MOTOR_IO_DEFS_VH

// Config switch bit positions
`define DIP_RESOLUTION_BIT 0
`define DIP_PULSE_MODE_BIT 1

// Resolution choices in pulses per revolution
`define RES_DEFAULT_PPR 16'd1000
`define RES_FINE_PPR    16'd10000

// Rotary switch factory positions
`define CURRENT_SW_DEFAULT 4'hf
`define FILTER_SW_DEFAULT  4'h1

// Timing (ns) and derived cycle counts at 25 MHz
`define CLOCK_PERIOD_NS   40
`define JOG_STEP_NS       1000000
`define JOG_STEP_CYCLES   (`JOG_STEP_NS / `CLOCK_PERIOD_NS)
`define HOME_STEP_NS      100000
`define HOME_STEP_CYCLES  (`HOME_STEP_NS / `CLOCK_PERIOD_NS)
`define BLINK_NS          250000000
`define BLINK_CYCLES      (`BLINK_NS / `CLOCK_PERIOD_NS)
`define FILTER_UNIT_NS    40000
`define FILTER_UNIT_CYC   (`FILTER_UNIT_NS / `CLOCK_PERIOD_NS)
`define SETTLE_NS         400000
`define SETTLE_CYCLES     (`SETTLE_NS / `CLOCK_PERIOD_NS)

`endif

//--- rtl/pulse_input_motor_driver_io.v
// Control-side logic of a pulse-input stepping motor driver
//
// Behaviour
// (R1) Red fault indicator blinks while any protection is active, dark otherwise.
// (R2) Green ready indicator lit exactly while the ready output is asserted.
// (R3) Switch position one selects resolution; off selects 1000 pulses per revolution.
// (R4) Switch position two selects pulse scheme; off selects two-pulse.
// (R5) Two-pulse: clockwise input steps clockwise, counter-clockwise input steps back.
// (R6) One-pulse: first pair carries steps, second pair carries direction level.
// (R7) Return-home command drives motor to the stored home position.
// (R8) De-energise command removes winding excitation.
// (R9) Forward or reverse jog command starts a jog in that direction.
// (R10) Home-done asserts after a return-home completes, once home is established.
// (R11) Pulse-ready asserts when the device can accept step pulses.
// (R12) Moving output held asserted for the whole time the motor moves.
// (R13) In-position output asserts when a movement has finished.
// (R14) Ready output asserts whenever operation commands can be accepted; ready_out ignores stop, so it stays asserted while stop refuses commands.
// (R15) Fault status output is normally closed: high normal, low on alarm.
// (R16) Rotary current switch sets base current; factory position F.
// (R17) Rotary filter switch sets command responsiveness; factory position 1.
// (R18) Stop halts motion; fault clear removes latched alarms.
// (R19) Quadrature phase A and B track motion; phase order shows direction.
`timescale 1ns/100ps
`default_nettype none
`include "motor_io_defs.vh"

module pulse_input_motor_driver_io #(
  parameter BLINK_CYCLES = `BLINK_CYCLES,
  parameter JOG_CYCLES   = `JOG_STEP_CYCLES,
  parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // Clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // Pulse inputs from the controller
  input  wire        clockwise_step_in,
  input  wire        counterclockwise_step_in,
  // Discrete commands
  input  wire        return_home_cmd,
  input  wire        stop_cmd,
  input  wire        deenergise_cmd,
  input  wire        fault_clear_cmd,
  input  wire        forward_inch_cmd,
  input  wire        reverse_inch_cmd,
  input  wire        home_preset_switch,
  // Protection sources
  input  wire        fault_event,
  // Switches
  input  wire [1:0]  config_dip_switch,
  input  wire [3:0]  current_rotary_switch,
  input  wire [3:0]  command_smoothing_switch,
  // Status outputs
  output reg         home_done_out,
  output reg         step_accept_ready_out,
  output reg         moving_out,
  output reg         in_position_out,
  output reg         ready_out,
  output reg         fault_status_nc_out,
  // Quadrature feedback
  output reg         quad_phase_a_out,
  output reg         quad_phase_b_out,
  // Indicators
  output reg         fault_led,
  output reg         ready_led,
  // Motor stage
  output reg         step_strobe,
  output reg         step_direction,
  output reg         excitation_on,
  output reg  [3:0]  base_current,
  output reg  [15:0] steps_per_rev,
  output reg  [31:0] position
);

  localparam S_IDLE = 4'b0001;
  localparam S_JOG  = 4'b0010;
  localparam S_HOME = 4'b0100;
  localparam S_FREE = 4'b1000;

  // Two-flop synchronisers on every pin input
  localparam NSYNC = 13;
  wire [NSYNC-1:0] rawIn = {fault_event, home_preset_switch, reverse_inch_cmd,
    forward_inch_cmd, fault_clear_cmd, deenergise_cmd, stop_cmd, return_home_cmd,
    config_dip_switch, counterclockwise_step_in, clockwise_step_in, 1'b0};
  reg  [NSYNC-1:0] syncA;
  reg  [NSYNC-1:0] syncB;
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : gSync
      always @(posedge clock) begin
        if (!reset_n) begin
          syncA[g] <= 1'b0;
          syncB[g] <= 1'b0;
        end else begin
          syncA[g] <= rawIn[g];
          syncB[g] <= syncA[g];
        end
      end
    end
  endgenerate

  // Rotary switches are pins too; reset to factory positions so
  // base current shows no dip while the flops refill after reset
  localparam [7:0] ROT_INIT = {`FILTER_SW_DEFAULT, `CURRENT_SW_DEFAULT};
  wire [7:0] rotRaw = {command_smoothing_switch, current_rotary_switch};
  reg  [7:0] rotA;
  reg  [7:0] rotB;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gRot
      always @(posedge clock) begin
        if (!reset_n) begin
          rotA[g] <= ROT_INIT[g];
          rotB[g] <= ROT_INIT[g];
        end else begin
          rotA[g] <= rotRaw[g];
          rotB[g] <= rotA[g];
        end
      end
    end
  endgenerate

  wire [3:0] curSwIn  = rotB[3:0];
  wire [3:0] filtSwIn = rotB[7:4];

  wire cwIn      = syncB[1];
  wire ccwIn     = syncB[2];
  wire dipRes    = syncB[3 + `DIP_RESOLUTION_BIT];
  wire dipMode   = syncB[3 + `DIP_PULSE_MODE_BIT]; // (R4)
  wire homeCmd   = syncB[5];
  wire stopIn    = syncB[6];
  wire freeIn    = syncB[7];
  wire clearIn   = syncB[8];
  wire fwdJog    = syncB[9];
  wire revJog    = syncB[10];
  wire presetIn  = syncB[11];
  wire faultIn   = syncB[12];

  reg  cwLast;
  reg  ccwLast;
  reg  homeLast;
  reg  presetLast;
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [31:0] homePos;
  reg         homeKnown;
  reg         faultLatched;
  reg  [23:0] stepTimer;
  reg  [23:0] blinkCount;
  reg         blinkPhase;
  reg  [23:0] settleCount;
  reg  [15:0] filterCount;
  reg  [1:0]  quadCount;

  wire cwRise   = cwIn & ~cwLast;
  wire ccwRise  = ccwIn & ~ccwLast;
  wire homeRise = homeCmd & ~homeLast;
  wire canRun   = ~faultLatched & ~freeIn & ~stopIn;

  // Pulse decode per scheme; one-pulse uses ccw pair as direction level
  wire pulseStep = dipMode ? cwRise : (cwRise ^ ccwRise); // (R5) (R6)
  wire pulseDir  = dipMode ? ~ccwIn : cwRise;            // (R5) (R6)
  wire pulseOk   = (state == S_IDLE) & canRun;

  // Filter scales a settle delay so position answer follows responsiveness
  function [15:0] filterLoad;
    input [3:0] sw;
    begin
      filterLoad = {12'h000, sw} * 16'd4;
    end
  endfunction

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (freeIn)
          next_state = S_FREE; // (R8)
        else if (canRun && homeRise && homeKnown)
          next_state = S_HOME; // (R7)
        else if (canRun && (fwdJog || revJog))
          next_state = S_JOG; // (R9)
      end
      S_JOG: begin
        if (freeIn)
          next_state = S_FREE;
        else if (!canRun || !(fwdJog || revJog))
          next_state = S_IDLE; // (R18)
      end
      S_HOME: begin
        if (freeIn)
          next_state = S_FREE;
        else if (!canRun || position == homePos)
          next_state = S_IDLE; // (R18)
      end
      S_FREE: begin
        if (!freeIn)
          next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // Stepping engine
  wire timedStep = (stepTimer == 24'h000000);
  wire jogDir    = fwdJog;
  wire homeDir   = ($signed(homePos - position) > 0);
  reg  doStep;
  reg  doDir;
  always @* begin
    doStep = 1'b0;
    doDir  = 1'b0;
    case (state)
      S_IDLE: begin
        doStep = pulseOk & pulseStep;
        doDir  = pulseDir;
      end
      S_JOG: begin
        doStep = timedStep & canRun & (fwdJog | revJog);
        doDir  = jogDir; // (R9)
      end
      S_HOME: begin
        doStep = timedStep & canRun & (position != homePos);
        doDir  = homeDir; // (R7)
      end
      default: begin
        doStep = 1'b0;
        doDir  = 1'b0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      cwLast      <= 1'b0;
      ccwLast     <= 1'b0;
      homeLast    <= 1'b0;
      presetLast  <= 1'b0;
      state       <= S_IDLE;
      homePos     <= 32'h00000000;
      homeKnown   <= 1'b0;
      faultLatched <= 1'b0;
      stepTimer   <= 24'h000000;
      position    <= 32'h00000000;
      quadCount   <= 2'h0;
      settleCount <= 24'h000000;
      filterCount <= 16'h0000;
      step_strobe <= 1'b0;
      step_direction <= 1'b0;
    end else begin
      cwLast     <= cwIn;
      ccwLast    <= ccwIn;
      homeLast   <= homeCmd;
      presetLast <= presetIn;
      state      <= next_state;
      // Set beats clear so a fault in the clear cycle is kept
      if (faultIn)
        faultLatched <= 1'b1;
      else if (clearIn)
        faultLatched <= 1'b0; // (R18)
      if (presetIn && !presetLast) begin
        homePos   <= position;
        homeKnown <= 1'b1;
      end
      if (state != next_state || timedStep)
        stepTimer <= JOG_CYCLES[23:0] - 24'h000001;
      else
        stepTimer <= stepTimer - 24'h000001;
      step_strobe    <= doStep;
      // Direction holds the last step's sense between strobes
      if (doStep)
        step_direction <= doDir;
      if (doStep) begin
        position  <= doDir ? position + 32'h00000001 : position - 32'h00000001;
        quadCount <= doDir ? quadCount + 2'h1 : quadCount - 2'h1; // (R19)
        settleCount <= SETTLE_CYCLES[23:0];
        filterCount <= filterLoad(filtSwIn); // (R17)
      end else begin
        if (settleCount != 24'h000000)
          settleCount <= settleCount - 24'h000001;
        if (filterCount != 16'h0000)
          filterCount <= filterCount - 16'h0001;
      end
    end
  end

  wire moving = (state == S_JOG) | (state == S_HOME) |
                (settleCount != 24'h000000) | (filterCount != 16'h0000);
  wire readyNow = ~faultLatched & ~freeIn & ~moving;

  // Outputs and blink timer
  always @(posedge clock) begin
    if (!reset_n) begin
      blinkCount <= 24'h000000;
      blinkPhase <= 1'b0;
      home_done_out <= 1'b0;
      step_accept_ready_out <= 1'b0;
      moving_out <= 1'b0;
      in_position_out <= 1'b0;
      ready_out <= 1'b0;
      fault_status_nc_out <= 1'b0;
      quad_phase_a_out <= 1'b0;
      quad_phase_b_out <= 1'b0;
      fault_led <= 1'b0;
      ready_led <= 1'b0;
      excitation_on <= 1'b0;
      base_current <= `CURRENT_SW_DEFAULT;
      steps_per_rev <= `RES_DEFAULT_PPR;
    end else begin
      if (faultLatched && blinkCount != 24'h000000) begin
        blinkCount <= blinkCount - 24'h000001;
      end else begin
        blinkCount <= BLINK_CYCLES[23:0] - 24'h000001;
        blinkPhase <= faultLatched & ~blinkPhase;
      end
      fault_led <= faultLatched & blinkPhase; // (R1)
      ready_led <= readyNow; // (R2)
      ready_out <= readyNow; // (R14)
      fault_status_nc_out <= ~faultLatched; // (R15)
      moving_out <= moving; // (R12)
      in_position_out <= ~moving & ~faultLatched; // (R13)
      step_accept_ready_out <= pulseOk; // (R11)
      // Home-done cleared by any later motion
      if (state == S_HOME && next_state == S_IDLE && position == homePos && homeKnown)
        home_done_out <= 1'b1; // (R10)
      else if (doStep)
        home_done_out <= 1'b0;
      quad_phase_a_out <= quadCount[1] ^ quadCount[0]; // (R19)
      quad_phase_b_out <= quadCount[1]; // (R19)
      excitation_on <= ~freeIn & ~faultLatched; // (R8)
      base_current <= curSwIn; // (R16)
      steps_per_rev <= dipRes ? `RES_FINE_PPR : `RES_DEFAULT_PPR; // (R3)
    end
  end

endmodule

`default_nettype wire

//--- testbench/motor_io_chk.sv
// Port checker for the motor driver control logic
`timescale 1ns/100ps
`default_nettype none
module motor_io_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Inputs
  input wire logic        stop_cmd,
  input wire logic        deenergise_cmd,
  input wire logic        fault_event,
  input wire logic [1:0]  config_dip_switch,
  input wire logic [3:0]  current_rotary_switch,
  // Outputs
  input wire logic        step_strobe,
  input wire logic        step_direction,
  input wire logic [31:0] position,
  input wire logic        moving_out,
  input wire logic        in_position_out,
  input wire logic        step_accept_ready_out,
  input wire logic        ready_out,
  input wire logic        ready_led,
  input wire logic        fault_status_nc_out,
  input wire logic        fault_led,
  input wire logic        excitation_on,
  input wire logic [3:0]  base_current,
  input wire logic [15:0] steps_per_rev,
  input wire logic        quad_phase_a_out,
  input wire logic        quad_phase_b_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Six samples cover the two sync flops plus state and output registers
  a_step_moves_pos: assert property (step_strobe |-> position == $past(position)
    + (step_direction ? 32'h1 : 32'hffffffff)) else $error("position step wrong");
  a_moving_after_step: assert property (step_strobe |=> moving_out && !in_position_out)
    else $error("moving flags wrong after step");
  a_quad_tracks_step: assert property (step_strobe |-> ##[1:2]
    ($changed(quad_phase_a_out) || $changed(quad_phase_b_out))) else $error("no quad edge");
  a_ready_led_mirror: assert property (ready_led == ready_out)
    else $error("ready led differs");
  a_stop_blocks_steps: assert property (stop_cmd [*6] |-> !step_strobe && !step_accept_ready_out)
    else $error("step while stopped");
  a_free_no_excite: assert property (deenergise_cmd [*6] |-> !excitation_on)
    else $error("excitation while free");
  a_fault_nc_low: assert property (fault_event [*6] |-> !fault_status_nc_out)
    else $error("fault status not released");
  a_fault_led_dark: assert property (fault_status_nc_out [*6] |-> !fault_led)
    else $error("fault led lit without fault");
  a_default_res: assert property (!config_dip_switch[0] [*6] |-> steps_per_rev == 16'h03e8)
    else $error("default resolution wrong");
  a_current_follows: assert property ($stable(current_rotary_switch) [*6]
    |-> base_current == current_rotary_switch) else $error("base current wrong");
endmodule
bind pulse_input_motor_driver_io motor_io_chk u_motor_io_chk (.clock, .reset_n, .stop_cmd,
  .deenergise_cmd, .fault_event, .config_dip_switch, .current_rotary_switch, .step_strobe,
  .step_direction, .position, .moving_out, .in_position_out, .step_accept_ready_out,
  .ready_out, .ready_led, .fault_status_nc_out, .fault_led, .excitation_on, .base_current,
  .steps_per_rev, .quad_phase_a_out, .quad_phase_b_out);
`default_nettype wire

//--- testbench/step_source.sv
// Controller model issuing step pulses and a direction level
`timescale 1ns/100ps
`default_nettype none
module step_source #(parameter int WIDTH = 8) (
  // Clock
  input wire logic clock,
  // Request
  input wire logic fire,
  input wire logic reverse,
  input wire logic onePulse,
  // Pulse lines
  output var logic lineA,
  output var logic lineB
);
  int   count = 0;
  logic useB  = 1'b0;
  logic mode  = 1'b0;
  logic dirLv = 1'b0;
  // Extra leading cycle gives the direction level setup before the step edge
  always @(posedge clock) begin
    if (fire && count == 0) begin
      count <= 2 * WIDTH + 1;
      useB  <= !onePulse && reverse;
      mode  <= onePulse;
      dirLv <= reverse;
    end else if (count != 0) begin
      count <= count - 1;
    end
  end
  wire high = count > WIDTH && count <= 2 * WIDTH;
  always @* begin
    lineA = high && !useB;
    lineB = mode ? dirLv : high && useB;
  end
endmodule
`default_nettype wire

//--- testbench/tb_pulse_input_motor_driver_io.sv
// Self-checking bench for the motor driver control logic
`timescale 1ns/100ps
`default_nettype none
module tb_pulse_input_motor_driver_io;
  logic clock = 0, reset_n = 0, fire = 0, rev = 0, mode = 0;
  logic homeCmd = 0, stopCmd = 0, freeCmd = 0, clearCmd = 0, fwdCmd = 0, revCmd = 0;
  logic presetSw = 0, faultEv = 0;
  logic [1:0] dip = 2'h0;
  logic [3:0] curSw = 4'hf, filtSw = 4'h1;
  wire cwIn, ccwIn, homeDone, pulseRdy, moving, inPos, ready, faultNc, qa, qb;
  wire faultLed, readyLed, strobe, dir, excite;
  wire [3:0] baseCur;
  wire [15:0] ppr;
  wire [31:0] pos;
  wire [8:0] flags = {ready, excite, pulseRdy, 1'b0, faultLed, faultNc, inPos, homeDone, 1'b0};
  int error_cnt = 0, check_count = 0;
  logic [31:0] exp, mark;
  always #20 clock = ~clock;
  step_source u_step_source (.clock(clock), .fire(fire), .reverse(rev), .onePulse(mode),
    .lineA(cwIn), .lineB(ccwIn));
  pulse_input_motor_driver_io #(.BLINK_CYCLES(8), .JOG_CYCLES(4), .SETTLE_CYCLES(4))
    u_pulse_input_motor_driver_io (.clock(clock), .reset_n(reset_n),
    .clockwise_step_in(cwIn), .counterclockwise_step_in(ccwIn), .return_home_cmd(homeCmd),
    .stop_cmd(stopCmd), .deenergise_cmd(freeCmd), .fault_clear_cmd(clearCmd),
    .forward_inch_cmd(fwdCmd), .reverse_inch_cmd(revCmd), .home_preset_switch(presetSw),
    .fault_event(faultEv), .config_dip_switch(dip), .current_rotary_switch(curSw),
    .command_smoothing_switch(filtSw), .home_done_out(homeDone),
    .step_accept_ready_out(pulseRdy), .moving_out(moving), .in_position_out(inPos),
    .ready_out(ready), .fault_status_nc_out(faultNc), .quad_phase_a_out(qa),
    .quad_phase_b_out(qb), .fault_led(faultLed), .ready_led(readyLed), .step_strobe(strobe),
    .step_direction(dir), .excitation_on(excite), .base_current(baseCur),
    .steps_per_rev(ppr), .position(pos));
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chkWord(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] pick(input int s);
    return s == 0 ? pos : s == 5 ? {16'h0, ppr} : {31'h0, flags[s]};
  endfunction
  // Bounded wait on one watched output; running out ends the run
  task automatic waitFor(input int s, input logic [31:0] e);
    for (int i = 0; i < 400; i++) begin
      @(posedge clock);
      #1;
      if (pick(s) === e) return;
    end
    chkWord("wait", e, pick(s));
    test_done;
  endtask
  task automatic stepPulse(input logic r);
    @(posedge clock);
    fire <= 1'b1;
    rev  <= r;
    @(posedge clock);
    fire <= 1'b0;
    repeat (20) @(posedge clock);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1;
    chkWord("baseCurReset", 32'hf, {28'h0, baseCur});
    chkWord("pprReset", 32'h3e8, {16'h0, ppr});
    reset_n <= 1'b1;
    exp = 0;
    for (int m = 0; m < 2; m++) begin
      for (int r = 0; r < 2; r++) begin
        @(posedge clock);
        mode   <= m[0];
        dip[1] <= m[0];
        repeat (10) @(posedge clock);
        stepPulse(r[0]);
        exp = r ? exp - 1 : exp + 1;
        waitFor(0, exp);
        chkWord("direction", {31'h0, !r[0]}, {31'h0, dir});
        waitFor(2, 1);
      end
    end
    $display("test pulse schemes done");
    dip[0] <= 1'b1;
    curSw  <= 4'h3;
    waitFor(5, 32'h2710);
    chkWord("baseCurrent", 32'h3, {28'h0, baseCur});
    dip[0] <= 1'b0;
    stopCmd <= 1'b1;
    repeat (10) @(posedge clock);
    stepPulse(1'b0);
    chkWord("stopPos", exp, pos);
    chkWord("pulseRdyStop", 0, {31'h0, pulseRdy});
    stopCmd <= 1'b0;
    waitFor(6, 1);
    $display("test switches and stop done");
    presetSw <= 1'b1;
    repeat (10) @(posedge clock);
    presetSw <= 1'b0;
    fwdCmd <= 1'b1;
    repeat (40) @(posedge clock);
    fwdCmd <= 1'b0;
    repeat (20) @(posedge clock);
    chkWord("jogForward", 1, {31'h0, $signed(pos) > $signed(exp)});
    mark = pos;
    revCmd <= 1'b1;
    repeat (20) @(posedge clock);
    revCmd <= 1'b0;
    repeat (20) @(posedge clock);
    chkWord("jogReverse", 1, {31'h0, $signed(pos) < $signed(mark)});
    homeCmd <= 1'b1;
    waitFor(1, 1);
    chkWord("homePos", exp, pos);
    homeCmd <= 1'b0;
    $display("test jog and home done");
    freeCmd <= 1'b1;
    waitFor(7, 0);
    freeCmd <= 1'b0;
    waitFor(7, 1);
    faultEv <= 1'b1;
    waitFor(3, 0);
    waitFor(4, 1);
    waitFor(4, 0);
    waitFor(8, 0);
    faultEv  <= 1'b0;
    clearCmd <= 1'b1;
    waitFor(3, 1);
    clearCmd <= 1'b0;
    waitFor(8, 1);
    chkWord("readyLed", 1, {31'h0, readyLed});
    $display("test free and fault done");
    test_done;
  end
endmodule
`default_nettype wire
